//--- logic/hid_pkg.sv
// Shared constants, register map and carrier types for the integer divider
package hid_pkg;

  // Datapath and bus widths
  localparam int unsigned HID_DW = 32;
  localparam int unsigned HID_AW = 8;

  // Register byte offsets
  localparam logic [7:0] HID_UNUM_OFS = 8'h60;
  localparam logic [7:0] HID_UDEN_OFS = 8'h64;
  localparam logic [7:0] HID_SNUM_OFS = 8'h68;
  localparam logic [7:0] HID_SDEN_OFS = 8'h6C;
  localparam logic [7:0] HID_QUO_OFS = 8'h70;
  localparam logic [7:0] HID_REM_OFS = 8'h74;
  localparam logic [7:0] HID_CSR_OFS = 8'h78;

  // Status field positions
  localparam int unsigned HID_READY_BIT = 0;
  localparam int unsigned HID_DIRTY_BIT = 1;

  // Reset values
  localparam logic [31:0] HID_RES_RST = 32'h00000000;
  localparam logic [31:0] HID_OPD_RST = 32'h00000000;
  localparam logic HID_READY_RST = 1'b1;
  localparam logic HID_DIRTY_RST = 1'b0;

  // Timing: cycles per calculation and bits retired per cycle
  localparam int unsigned HID_CALC_CYCLES = 8;
  localparam int unsigned HID_STEPS = HID_DW / HID_CALC_CYCLES;
  localparam logic [2:0] HID_CNT_LAST = 3'(HID_CALC_CYCLES - 1);

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [HID_AW-1:0] addr;
    logic [HID_DW-1:0] wdata;
  } hid_bus_req_t;

  // Iterative core state
  typedef struct packed {
    logic busy;
    logic [2:0] cnt;
    logic [HID_DW-1:0] quo;
    logic [HID_DW-1:0] rem;
    logic [HID_DW-1:0] den;
  } hid_core_st_t;

  // Core finish indication with unsigned magnitudes
  typedef struct packed {
    logic fin;
    logic [HID_DW-1:0] quo;
    logic [HID_DW-1:0] rem;
  } hid_core_res_t;

  // Register-file state
  typedef struct packed {
    logic [HID_DW-1:0] dend;
    logic [HID_DW-1:0] dsor;
    logic [HID_DW-1:0] quo;
    logic [HID_DW-1:0] rem;
    logic sgn;
    logic neg_q;
    logic neg_r;
    logic ready;
    logic dirty;
    logic [HID_DW-1:0] rdata;
  } hid_top_st_t;

endpackage : hid_pkg

//--- logic/hid_sign_fix.sv
// Conditional two's complement negation for operands and results
`timescale 1ns/10ps
`default_nettype none

module hid_sign_fix
  import hid_pkg::*;
(
  input wire logic [HID_DW-1:0] val_i,
  input wire logic neg_i,
  output var logic [HID_DW-1:0] val_o
);

  // Negate when asked; the most negative value maps onto itself
  always_comb
  begin
    if (neg_i)
    begin
      val_o = ~val_i + 32'h00000001;
    end
    else
    begin
      val_o = val_i;
    end
  end

endmodule : hid_sign_fix

`default_nettype wire

//--- logic/hid_div_core.sv
// Unsigned restoring divider retiring several quotient bits per cycle
`timescale 1ns/10ps
`default_nettype none

module hid_div_core
  import hid_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [HID_DW-1:0] dend_i,
  input wire logic [HID_DW-1:0] dsor_i,
  output var hid_core_res_t res_o
);

  hid_core_st_t st_ff; // Registered core state
  hid_core_st_t nxt_st; // Next core state
  logic [HID_DW:0] part; // Partial remainder with shifted-in bit

  // Step, finish, abort and restart decisions
  always_comb
  begin
    part = '0;
    nxt_st = st_ff;
    res_o = '0;
    if (st_ff.busy)
    begin
      // Zero divisor simply yields all-ones quotient, never stalls
      for (int i = 0; i < int'(HID_STEPS); i++)
      begin
        part = {nxt_st.rem, nxt_st.quo[HID_DW-1]};
        nxt_st.quo = {nxt_st.quo[HID_DW-2:0], 1'b0};
        if (part >= {1'b0, nxt_st.den})
        begin
          part = part - {1'b0, nxt_st.den};
          nxt_st.quo[0] = 1'b1;
        end
        nxt_st.rem = part[HID_DW-1:0];
      end
      nxt_st.cnt = st_ff.cnt + 3'h1;
      // Last step: hand magnitudes out combinationally
      if (st_ff.cnt == HID_CNT_LAST)
      begin
        nxt_st.busy = 1'b0;
        res_o.fin = 1'b1;
      end
    end
    res_o.quo = nxt_st.quo;
    res_o.rem = nxt_st.rem;
    // Kill work in flight
    if (abort_i)
    begin
      nxt_st.busy = 1'b0;
    end
    // Fresh operands always win over an old calculation
    if (start_i)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = 3'h0;
      nxt_st.quo = dend_i;
      nxt_st.rem = '0;
      nxt_st.den = dsor_i;
    end
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule : hid_div_core

`default_nettype wire

//--- logic/hid_divider.sv
// Memory-mapped integer divider: register file, control and assertions
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module hid_divider
  import hid_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire hid_bus_req_t req_i,
  output logic [HID_DW-1:0] rdata_o,
  output logic calc_done_flag_o,
  output logic state_modified_flag_o
);

  hid_top_st_t st_ff; // Registered block state
  hid_top_st_t nxt_st; // Next block state

  // Address decode strobes
  logic num_hit; // Either dividend alias
  logic den_hit; // Either divisor alias
  logic quo_hit; // Quotient result
  logic rem_hit; // Remainder result
  logic csr_hit; // Status register
  logic sgn_hit; // Signed alias addressed
  logic map_hit; // Any mapped offset

  // Access qualifiers
  logic op_wr; // Operand write, starts a calculation
  logic res_wr; // Result write, aborts a calculation
  logic wr_hit; // Any mapped write
  logic quo_rd; // Quotient read
  logic rem_rd; // Remainder read

  // Operand values as they will be after this cycle
  logic [HID_DW-1:0] new_dend;
  logic [HID_DW-1:0] new_dsor;
  logic new_sgn;
  logic new_neg_n; // Dividend negative in signed mode
  logic new_neg_d; // Divisor negative in signed mode

  // Magnitudes and signed results
  logic [HID_DW-1:0] mag_dend;
  logic [HID_DW-1:0] mag_dsor;
  logic [HID_DW-1:0] fix_quo;
  logic [HID_DW-1:0] fix_rem;

  hid_core_res_t core_res; // Core finish and magnitudes
  logic fin_take; // Finish not overridden by an operand or result write

  // Decode: operand aliases share one register each
  always_comb
  begin
    num_hit = 1'b0;
    den_hit = 1'b0;
    quo_hit = 1'b0;
    rem_hit = 1'b0;
    csr_hit = 1'b0;
    sgn_hit = 1'b0;
    case (req_i.addr)
      HID_UNUM_OFS: num_hit = 1'b1;
      HID_SNUM_OFS:
      begin
        num_hit = 1'b1;
        sgn_hit = 1'b1;
      end
      HID_UDEN_OFS: den_hit = 1'b1;
      HID_SDEN_OFS:
      begin
        den_hit = 1'b1;
        sgn_hit = 1'b1;
      end
      HID_QUO_OFS: quo_hit = 1'b1;
      HID_REM_OFS: rem_hit = 1'b1;
      HID_CSR_OFS: csr_hit = 1'b1;
      // Unmapped offsets: writes dropped, reads give zero
      default: num_hit = 1'b0;
    endcase
    map_hit = num_hit | den_hit | quo_hit | rem_hit | csr_hit;
  end

  // Access qualifiers from the strobes
  always_comb
  begin
    op_wr = req_i.wr & (num_hit | den_hit);
    res_wr = req_i.wr & (quo_hit | rem_hit);
    wr_hit = req_i.wr & map_hit;
    quo_rd = req_i.rd & quo_hit;
    rem_rd = req_i.rd & rem_hit;
  end

  // Operand values the core starts from
  always_comb
  begin
    new_dend = (req_i.wr & num_hit) ? req_i.wdata : st_ff.dend;
    new_dsor = (req_i.wr & den_hit) ? req_i.wdata : st_ff.dsor;
    new_sgn = op_wr ? sgn_hit : st_ff.sgn;
    new_neg_n = new_sgn & new_dend[HID_DW-1];
    new_neg_d = new_sgn & new_dsor[HID_DW-1];
  end

  // Operand magnitudes for the unsigned core
  hid_sign_fix u_abs_dend (
    .val_i(new_dend),
    .neg_i(new_neg_n),
    .val_o(mag_dend)
  );

  hid_sign_fix u_abs_dsor (
    .val_i(new_dsor),
    .neg_i(new_neg_d),
    .val_o(mag_dsor)
  );

  // Iterative core; an operand write restarts it, a result write kills it
  hid_div_core u_core (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .start_i(op_wr),
    .abort_i(res_wr),
    .dend_i(mag_dend),
    .dsor_i(mag_dsor),
    .res_o(core_res)
  );

  // Apply result signs recorded at start
  hid_sign_fix u_sgn_quo (
    .val_i(core_res.quo),
    .neg_i(st_ff.neg_q),
    .val_o(fix_quo)
  );

  hid_sign_fix u_sgn_rem (
    .val_i(core_res.rem),
    .neg_i(st_ff.neg_r),
    .val_o(fix_rem)
  );

  // An operand or result write in the finishing cycle supersedes the result
  assign fin_take = core_res.fin & ~op_wr & ~res_wr;

  // Next-state logic for registers, flags and read data
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = '0;
    nxt_st.dend = new_dend;
    nxt_st.dsor = new_dsor;
    // New calculation: remember signs and drop ready
    if (op_wr)
    begin
      nxt_st.sgn = new_sgn;
      nxt_st.neg_q = new_neg_n ^ new_neg_d;
      nxt_st.neg_r = new_neg_n;
      nxt_st.ready = 1'b0;
    end
    // Completion: store signed results, raise ready
    if (fin_take)
    begin
      nxt_st.quo = fix_quo;
      nxt_st.rem = fix_rem;
      nxt_st.ready = 1'b1;
    end
    // Context restore: direct result writes
    if (req_i.wr & quo_hit)
    begin
      nxt_st.quo = req_i.wdata;
    end
    if (req_i.wr & rem_hit)
    begin
      nxt_st.rem = req_i.wdata;
    end
    if (res_wr)
    begin
      nxt_st.ready = 1'b1;
    end
    // Dirty: a mapped write sets; a quotient read clears
    if (wr_hit)
    begin
      nxt_st.dirty = 1'b1;
    end
    else if (quo_rd)
    begin
      nxt_st.dirty = 1'b0;
    end
    // Read mux; results read as stored even while busy
    if (req_i.rd)
    begin
      if (num_hit)
      begin
        nxt_st.rdata = st_ff.dend;
      end
      else if (den_hit)
      begin
        nxt_st.rdata = st_ff.dsor;
      end
      else if (quo_hit)
      begin
        nxt_st.rdata = st_ff.quo;
      end
      else if (rem_hit)
      begin
        nxt_st.rdata = st_ff.rem;
      end
      else if (csr_hit)
      begin
        nxt_st.rdata[HID_DIRTY_BIT] = st_ff.dirty;
        nxt_st.rdata[HID_READY_BIT] = st_ff.ready;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_ff <= '0;
      st_ff.dend <= HID_OPD_RST;
      st_ff.dsor <= HID_OPD_RST;
      st_ff.quo <= HID_RES_RST;
      st_ff.rem <= HID_RES_RST;
      st_ff.ready <= HID_READY_RST;
      st_ff.dirty <= HID_DIRTY_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign rdata_o = st_ff.rdata;
  assign calc_done_flag_o = st_ff.ready;
  assign state_modified_flag_o = st_ff.dirty;

  // Reference results, read only by assertions
  logic [HID_DW-1:0] ref_q;
  logic [HID_DW-1:0] ref_r;
  logic ref_qneg;
  always_comb
  begin
    ref_q = '0;
    ref_r = '0;
    if (st_ff.dsor != '0)
    begin
      ref_q = st_ff.sgn ? 32'($signed(st_ff.dend) / $signed(st_ff.dsor))
                        : st_ff.dend / st_ff.dsor;
      ref_r = st_ff.sgn ? 32'($signed(st_ff.dend) % $signed(st_ff.dsor))
                        : st_ff.dend % st_ff.dsor;
    end
    ref_qneg = st_ff.sgn & (st_ff.dend[HID_DW-1] ^ st_ff.dsor[HID_DW-1]) & (ref_q != '0);
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  property p_op_busy;
    op_wr |=> !st_ff.ready;
  endproperty
  a_op_busy: assert property (p_op_busy) else $error("ready not cleared by operand write");

  property p_calc_len;
    op_wr ##1 (!req_i.wr)[*8] |=> st_ff.ready && $past(!st_ff.ready);
  endproperty
  a_calc_len: assert property (p_calc_len) else $error("calculation length wrong");

  property p_res_wr;
    res_wr |=> st_ff.ready && st_ff.dirty;
  endproperty
  a_res_wr: assert property (p_res_wr) else $error("result write flags wrong");

  property p_wr_dirty;
    wr_hit |=> st_ff.dirty;
  endproperty
  a_wr_dirty: assert property (p_wr_dirty) else $error("write did not set dirty");

  property p_quo_rd;
    quo_rd |=> !st_ff.dirty;
  endproperty
  a_quo_rd: assert property (p_quo_rd) else $error("quotient read left dirty");

  property p_rem_rd;
    rem_rd |=> $stable(st_ff.dirty);
  endproperty
  a_rem_rd: assert property (p_rem_rd) else $error("remainder read changed dirty");

  property p_res_val;
    req_i.wr && quo_hit |=> st_ff.quo == $past(req_i.wdata) ##1
      (rdata_o == $past(st_ff.quo) || !$past(quo_rd));
  endproperty
  a_res_val: assert property (p_res_val) else $error("quotient write not held");

  property p_csr_rd;
    req_i.rd && csr_hit |=> rdata_o == {30'h0, $past(st_ff.dirty), $past(st_ff.ready)};
  endproperty
  a_csr_rd: assert property (p_csr_rd) else $error("status readback wrong");

  property p_rst_val;
    disable iff (1'b0) srst_i |=> st_ff.quo == '0 && st_ff.rem == '0 && st_ff.ready;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");

  property p_result;
    fin_take && st_ff.dsor != '0 |=> st_ff.quo == $past(ref_q) && st_ff.rem == $past(ref_r);
  endproperty
  a_result: assert property (p_result) else $error("division result wrong");

  property p_qsign;
    fin_take && st_ff.dsor != '0 |=> st_ff.quo[31] == $past(ref_qneg) || !$past(st_ff.sgn);
  endproperty
  a_qsign: assert property (p_qsign) else $error("quotient sign wrong");

  property p_rsign;
    fin_take && st_ff.sgn && !st_ff.dend[31] |=> !st_ff.rem[31];
  endproperty
  a_rsign: assert property (p_rsign) else $error("remainder sign wrong");

  property p_alias;
    req_i.rd && num_hit |=> rdata_o == $past(st_ff.dend);
  endproperty
  a_alias: assert property (p_alias) else $error("dividend alias readback wrong");

  c_finish: cover property (op_wr ##1 (!req_i.wr)[*8] ##1 st_ff.ready);
  c_abort: cover property (op_wr ##[1:7] res_wr);
  c_clean: cover property (rem_rd ##[1:2] quo_rd ##1 !st_ff.dirty);
  c_zero: cover property (fin_take && st_ff.dsor == '0);

endmodule : hid_divider

`default_nettype wire

//--- verif/test_hardware_integer_divider.sv
// Self-checking testbench for the memory-mapped integer divider
`timescale 1ns/10ps
`default_nettype none

module test_hardware_integer_divider
  import hid_pkg::*;
  ;

  logic core_clk_i; // 50 MHz system clock
  logic srst_i; // Synchronous reset, active high
  hid_bus_req_t req; // Register port request
  logic [HID_DW-1:0] rdata; // Read data, one cycle after rd
  logic ready; // Calculation done flag
  logic dirty; // State modified flag
  int n_fail; // Mismatch counter
  int tests_run; // Comparison counter

  // Device under test
  hid_divider dut_u (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .req_i(req),
    .rdata_o(rdata),
    .calc_done_flag_o(ready),
    .state_modified_flag_o(dirty)
  );

  // Clock generator, 20 ns period
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // Word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Flag comparison; four-state so an unknown flag never matches
  task automatic chkb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkb

  // One-cycle write; returns at the edge that takes it
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    req <= '0;
  endtask : bus_wr

  // One-cycle read; data sampled in the following cycle only
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge core_clk_i);
    req <= '0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // Busy for exactly the calculation length after the last operand write
  task automatic calc_walk();
    for (int i = 0; i < HID_CALC_CYCLES; i++)
    begin
      #1;
      chkb(ready, 1'b0);
      @(posedge core_clk_i);
    end
    #1;
    chkb(ready, 1'b1);
  endtask : calc_walk

  // Values straight out of reset
  task automatic t_reset();
    chkb(ready, 1'b1);
    chkb(dirty, 1'b0);
    rd_chk(HID_CSR_OFS, 32'h00000001);
    rd_chk(HID_REM_OFS, 32'h00000000);
    rd_chk(HID_QUO_OFS, 32'h00000000);
  endtask : t_reset

  // Unsigned division, read order and alias read-back
  task automatic t_unsigned();
    logic [31:0] a;
    logic [31:0] b;
    a = 32'hF001_2345;
    b = 32'h0000_0007;
    bus_wr(HID_UNUM_OFS, a);
    bus_wr(HID_UDEN_OFS, b);
    calc_walk();
    chkb(dirty, 1'b1);
    rd_chk(HID_CSR_OFS, 32'h00000003);
    rd_chk(HID_REM_OFS, a % b);
    chkb(dirty, 1'b1);
    rd_chk(HID_QUO_OFS, a / b);
    chkb(dirty, 1'b0);
    rd_chk(HID_SNUM_OFS, a);
    rd_chk(HID_UNUM_OFS, a);
    rd_chk(HID_SDEN_OFS, b);
    rd_chk(HID_UDEN_OFS, b);
    // Unmapped write must leave the flag clean
    bus_wr(8'h7C, 32'hFFFF_FFFF);
    #1;
    chkb(dirty, 1'b0);
    rd_chk(8'h7C, 32'h00000000);
  endtask : t_unsigned

  // Sign combinations through the signed aliases
  task automatic t_signed();
    logic [31:0] ta [3] = '{32'hFFFF_FFF9, 32'h0000_0007, 32'hFFFF_FFF9};
    logic [31:0] tb [3] = '{32'h0000_0002, 32'hFFFF_FFFE, 32'hFFFF_FFFE};
    logic [31:0] q;
    logic [31:0] r;
    for (int i = 0; i < 3; i++)
    begin
      bus_wr(HID_SNUM_OFS, ta[i]);
      bus_wr(HID_SDEN_OFS, tb[i]);
      calc_walk();
      q = $signed(ta[i]) / $signed(tb[i]);
      r = $signed(ta[i]) % $signed(tb[i]);
      rd_chk(HID_REM_OFS, r);
      rd_chk(HID_QUO_OFS, q);
    end
    // Unsigned alias reuses the stored divisor but drops signed mode
    bus_wr(HID_UNUM_OFS, 32'hFFFF_FFF9);
    calc_walk();
    rd_chk(HID_REM_OFS, 32'hFFFF_FFF9);
    rd_chk(HID_QUO_OFS, 32'h00000000);
  endtask : t_signed

  // Operand write in mid-calculation starts over
  task automatic t_restart();
    bus_wr(HID_UNUM_OFS, 32'h0000_0064);
    bus_wr(HID_UDEN_OFS, 32'h0000_0003);
    repeat (3) @(posedge core_clk_i);
    bus_wr(HID_UDEN_OFS, 32'h0000_0007);
    calc_walk();
    rd_chk(HID_QUO_OFS, 32'h0000_000E);
    rd_chk(HID_REM_OFS, 32'h0000_0002);
  endtask : t_restart

  // Result writes abort and restore; status stays read-only
  task automatic t_abort();
    bus_wr(HID_UNUM_OFS, 32'h0000_03E8);
    bus_wr(HID_UDEN_OFS, 32'h0000_0009);
    repeat (2) @(posedge core_clk_i);
    bus_wr(HID_QUO_OFS, 32'hCAFE_0001);
    #1;
    chkb(ready, 1'b1);
    chkb(dirty, 1'b1);
    // Aborted result must never land later
    repeat (10) @(posedge core_clk_i);
    rd_chk(HID_QUO_OFS, 32'hCAFE_0001);
    chkb(dirty, 1'b0);
    bus_wr(HID_REM_OFS, 32'h1234_5678);
    #1;
    chkb(dirty, 1'b1);
    rd_chk(HID_REM_OFS, 32'h1234_5678);
    rd_chk(HID_QUO_OFS, 32'hCAFE_0001);
    bus_wr(HID_CSR_OFS, 32'hFFFF_FFFF);
    rd_chk(HID_CSR_OFS, 32'h00000003);
    // Restore then read back with no idle cycle between
    @(posedge core_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: HID_QUO_OFS, wdata: 32'h0BAD_F00D};
    @(posedge core_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: HID_QUO_OFS, wdata: '0};
    @(posedge core_clk_i);
    req <= '0;
    #1;
    chk(rdata, 32'h0BAD_F00D);
    chkb(dirty, 1'b0);
  endtask : t_abort

  // Zero divisor must not hang; bounded wait for ready
  task automatic t_divzero();
    int n;
    bus_wr(HID_UNUM_OFS, 32'h0000_0005);
    bus_wr(HID_UDEN_OFS, 32'h0000_0000);
    n = 0;
    #1;
    while (ready !== 1'b1 && n < 20)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      n_fail++;
      conclude();
    end
    chkb(ready, 1'b1);
  endtask : t_divzero

  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial
  begin
    req = '0;
    srst_i = 1'b1;
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    t_reset();
    t_unsigned();
    t_signed();
    t_restart();
    t_abort();
    t_divzero();
    conclude();
  end

endmodule : test_hardware_integer_divider

`default_nettype wire
